// >>> rtl/psc_pkg.sv
// Constants and types shared by the power-on strap configuration block.
package psc_pkg;

    // ----------------------------------------------------------------
    // Widths.
    // ----------------------------------------------------------------
    localparam int STRAP_W = 18;  // Number of strap pins.
    localparam int CNT_W = 16;    // Width of each termination counter.

    // ----------------------------------------------------------------
    // Register byte offsets.
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_STRAP = 4'h0;   // Raw captured strap levels.
    localparam logic [3:0] REG_DECODE = 4'h4;  // Decoded settings.
    localparam logic [3:0] REG_TERM = 4'h8;    // Termination counters.
    localparam logic [3:0] REG_CTRL = 4'hC;    // Control, write only.
    localparam int CTRL_CLR = 0;               // Write one clears counters.
    localparam int DEC_VALID = 24;             // Decode register valid bit.
    localparam int DEC_PIN = 25;               // Level seen on channel pin b.

    // ----------------------------------------------------------------
    // Strap bit positions.
    // ----------------------------------------------------------------
    localparam int SB_ROW_LSB = 0;
    localparam int SB_ROW_MSB = 3;
    localparam int SB_PAGE_LSB = 4;
    localparam int SB_PAGE_MSB = 5;
    localparam int SB_BWS = 6;
    localparam int SB_UMA = 7;
    localparam int SB_A9R = 10;
    localparam int SB_EMC = 12;
    localparam int SB_EDC = 13;
    localparam int SB_FCN = 14;
    localparam int SB_STV = 15;
    localparam int SB_RTD = 16;
    localparam int SB_CRD = 17;

    // ----------------------------------------------------------------
    // Field codes and bus answers.
    // ----------------------------------------------------------------
    localparam logic [3:0] ROW_SLOW = 4'h0;   // Slowest row timing code.
    localparam logic [3:0] ROW_LAST = 4'hD;   // Highest defined row code.
    localparam logic [1:0] PAGE_SLOW = 2'h0;  // Two-clock fast-page cycle.
    localparam logic [1:0] PAGE_RSVD = 2'h3;  // Reserved page-cycle code.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded settings handed to the rest of the chip.
    typedef struct packed {
        logic [3:0] row_strobe_timing_sel;  // Effective row timing code.
        logic [3:0] ras_precharge_half;     // Precharge in half memory clocks.
        logic [3:0] ras_low_half;           // Strobe low in half memory clocks.
        logic [1:0] page_cycle_type_sel;    // Effective page cycle code.
        logic byte_write_style_sel;         // High means dual column strobes.
        logic shared_memory_enable;
        logic addr_bit9_pin_route;          // High routes via output enable.
        logic external_memory_clock_sel;
        logic memory_clock_from_cpu;        // External memory clock is CPU clock.
        logic external_dot_clock_sel;
        logic feature_connector_narrow;
        logic stereo_view_enable;
        logic bus_retry_disable;
        logic cfg_rom_disconnect_disable;
    } psc_cfg_t;

    // Termination states, one-hot.
    typedef enum logic [3:0] {
        TS_IDLE = 4'h1,
        TS_XFER = 4'h2,
        TS_RETRY = 4'h4,
        TS_DISC = 4'h8
    } psc_term_t;

    // Row timing table: precharge and low times in half memory clocks.
    function automatic logic [7:0] psc_row_times(input logic [3:0] code);
        case (code)
            4'h0: psc_row_times = 8'h7B;
            4'h1: psc_row_times = 8'h79;
            4'h2: psc_row_times = 8'h77;
            4'h3: psc_row_times = 8'h59;
            4'h4: psc_row_times = 8'h57;
            4'h5: psc_row_times = 8'h55;
            4'h6: psc_row_times = 8'h37;
            4'h7: psc_row_times = 8'h35;
            4'h8: psc_row_times = 8'h6C;
            4'h9: psc_row_times = 8'h6A;
            4'hA: psc_row_times = 8'h68;
            4'hB: psc_row_times = 8'h4A;
            4'hC: psc_row_times = 8'h48;
            4'hD: psc_row_times = 8'h46;
            default: psc_row_times = 8'h7B;
        endcase
    endfunction : psc_row_times

endpackage : psc_pkg

// >>> rtl/psc_strap_config.sv
// Strap capture, decode, pin routing, termination policy and register slave.
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
module psc_strap_config (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic bus_reset_in_n_i,
    input wire logic [psc_pkg::STRAP_W-1:0] memory_data_strap_pins_i,
    input wire logic interlaced_i,
    input wire logic odd_field_i,
    input wire logic memory_address_bit9_i,
    input wire logic write_enable_b_int_i,
    input wire logic output_enable_int_i,
    output logic second_write_enable_pin_o,
    output logic output_enable_pin_o,
    input wire logic display_channel_pin_b_i,
    output logic display_channel_pin_b_o,
    output logic display_channel_pin_b_oe_o,
    output psc_pkg::psc_cfg_t cfg_o,
    output logic strap_valid_o,
    input wire logic xact_i,
    input wire logic data_ready_i,
    input wire logic stop_req_i,
    input wire logic cfg_rom_access_i,
    output logic trdy_o,
    output logic stop_o,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import psc_pkg::*;

    // ----------------------------------------------------------------
    // Reset release and pin synchronisers.
    // ----------------------------------------------------------------
    logic rst_meta;  // First reset flop.
    logic rst_n;     // Reset used by the whole block.
    logic [STRAP_W+1:0] pin_meta;  // First stage of pin synchroniser.
    logic [STRAP_W+1:0] pin_sync;  // Second stage, safe to read.
    logic breset_s;  // Synchronised bus reset, low while asserted.
    logic breset_d;  // Bus reset delayed one more cycle.
    logic [STRAP_W-1:0] strap_s;  // Synchronised strap levels.

    // Reset asserts at once and releases through two flops.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pins cross in through two flops before any logic reads them.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
            breset_d <= 1'b0;
        end else begin
            pin_meta <= {display_channel_pin_b_i, bus_reset_in_n_i, memory_data_strap_pins_i};
            pin_sync <= pin_meta;
            breset_d <= pin_sync[STRAP_W];
        end
    end

    assign breset_s = pin_sync[STRAP_W];
    assign strap_s = pin_sync[STRAP_W-1:0];

    // ----------------------------------------------------------------
    // Strap capture and decode.
    // ----------------------------------------------------------------
    logic [STRAP_W-1:0] strap, next_strap;  // Captured strap levels.
    logic strap_valid, next_strap_valid;    // Capture has happened.
    psc_cfg_t cfg, next_cfg;                // Decoded settings.
    logic [3:0] row_code;                   // Effective row code.
    logic [7:0] row_times;                  // Row table lookup.

    // Straps are cleared while bus reset is held, caught on its release,
    // then held untouched until bus reset asserts again.
    always_comb begin
        next_strap = strap;
        next_strap_valid = strap_valid;
        if (!breset_s) begin
            next_strap = '0;
            next_strap_valid = 1'b0;
        end else if (!breset_d) begin
            next_strap = strap_s;
            next_strap_valid = 1'b1;
        end
        // Reserved row codes take the slowest timing.
        row_code = next_strap[SB_ROW_MSB:SB_ROW_LSB];
        if (row_code > ROW_LAST) begin
            row_code = ROW_SLOW;
        end
        row_times = psc_row_times(row_code);
        next_cfg.row_strobe_timing_sel = row_code;
        next_cfg.ras_precharge_half = row_times[7:4];
        next_cfg.ras_low_half = row_times[3:0];
        next_cfg.page_cycle_type_sel = next_strap[SB_PAGE_MSB:SB_PAGE_LSB];
        if (next_cfg.page_cycle_type_sel == PAGE_RSVD) begin
            next_cfg.page_cycle_type_sel = PAGE_SLOW;
        end
        next_cfg.byte_write_style_sel = next_strap[SB_BWS];
        next_cfg.shared_memory_enable = next_strap[SB_UMA];
        next_cfg.addr_bit9_pin_route = next_strap[SB_A9R];
        next_cfg.external_memory_clock_sel = next_strap[SB_EMC];
        next_cfg.memory_clock_from_cpu = next_strap[SB_EMC] & next_strap[SB_UMA];
        next_cfg.external_dot_clock_sel = next_strap[SB_EDC];
        next_cfg.feature_connector_narrow = next_strap[SB_FCN];
        next_cfg.stereo_view_enable = next_strap[SB_STV];
        next_cfg.bus_retry_disable = next_strap[SB_RTD];
        next_cfg.cfg_rom_disconnect_disable = next_strap[SB_CRD];
    end

    // Registers the captured straps and their decode.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            strap <= '0;
            strap_valid <= 1'b0;
            cfg <= '0;
        end else begin
            strap <= next_strap;
            strap_valid <= next_strap_valid;
            cfg <= next_cfg;
        end
    end

    assign cfg_o = cfg;
    assign strap_valid_o = strap_valid;

    // ----------------------------------------------------------------
    // Memory pin routing and stereo output.
    // ----------------------------------------------------------------
    logic second_write_enable_pin, next_second_write_enable_pin, output_enable_pin, next_oeb, pin_b, next_pin_b, pin_b_oe, next_pin_b_oe;

    // Address nine borrows a control pin only in shared memory mode.
    always_comb begin
        next_second_write_enable_pin = write_enable_b_int_i;
        next_oeb = output_enable_int_i;
        if (cfg.shared_memory_enable && !cfg.addr_bit9_pin_route) begin
            next_second_write_enable_pin = memory_address_bit9_i;
        end
        if (cfg.shared_memory_enable && cfg.addr_bit9_pin_route) begin
            next_oeb = memory_address_bit9_i;
        end
        // Stereo control is high only on odd interlaced fields.
        next_pin_b_oe = cfg.stereo_view_enable;
        next_pin_b = cfg.stereo_view_enable & interlaced_i & odd_field_i;
    end

    // Registers the routed pins.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            second_write_enable_pin <= 1'b1;
            output_enable_pin <= 1'b1;
            pin_b <= 1'b0;
            pin_b_oe <= 1'b0;
        end else begin
            second_write_enable_pin <= next_second_write_enable_pin;
            output_enable_pin <= next_oeb;
            pin_b <= next_pin_b;
            pin_b_oe <= next_pin_b_oe;
        end
    end

    assign second_write_enable_pin_o = second_write_enable_pin;
    assign output_enable_pin_o = output_enable_pin;
    assign display_channel_pin_b_o = pin_b;
    assign display_channel_pin_b_oe_o = pin_b_oe;

    // ----------------------------------------------------------------
    // Target termination policy.
    // ----------------------------------------------------------------
    psc_term_t state, next_state;       // Termination state.
    logic trdy_seen, next_trdy_seen;    // Ready given in this transaction.
    logic [CNT_W-1:0] retry_cnt, next_retry_cnt, disc_cnt, next_disc_cnt;
    logic disc_ok;  // Disconnect allowed for this access.
    logic clr_cnt;  // Counter clear from software.

    // Chooses ready, retry or disconnect for the claimed transaction.
    always_comb begin
        next_state = state;
        next_trdy_seen = trdy_seen;
        next_retry_cnt = retry_cnt;
        next_disc_cnt = disc_cnt;
        trdy_o = 1'b0;
        stop_o = 1'b0;
        disc_ok = !(cfg_rom_access_i && cfg.cfg_rom_disconnect_disable);
        if (clr_cnt) begin
            next_retry_cnt = '0;
            next_disc_cnt = '0;
        end
        case (state)
            TS_IDLE: begin
                next_trdy_seen = 1'b0;
                if (xact_i) begin
                    next_state = TS_XFER;
                end
            end
            TS_XFER: begin
                if (!xact_i) begin
                    next_state = TS_IDLE;
                end else if (stop_req_i && data_ready_i && disc_ok) begin
                    trdy_o = 1'b1;
                    stop_o = 1'b1;
                    next_state = TS_DISC;
                    next_disc_cnt = next_disc_cnt + 1'b1;
                end else if (stop_req_i && !data_ready_i && !trdy_seen
                             && !cfg.bus_retry_disable) begin
                    stop_o = 1'b1;
                    next_state = TS_RETRY;
                    next_retry_cnt = next_retry_cnt + 1'b1;
                end else begin
                    trdy_o = data_ready_i;
                    next_trdy_seen = trdy_seen | data_ready_i;
                end
            end
            TS_RETRY, TS_DISC: begin
                stop_o = 1'b1;
                if (!xact_i) begin
                    next_state = TS_IDLE;
                end
            end
            default: begin
                next_state = TS_IDLE;
            end
        endcase
    end

    // Registers the termination state and counters.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= TS_IDLE;
            trdy_seen <= 1'b0;
            retry_cnt <= '0;
            disc_cnt <= '0;
        end else begin
            state <= next_state;
            trdy_seen <= next_trdy_seen;
            retry_cnt <= next_retry_cnt;
            disc_cnt <= next_disc_cnt;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite register slave.
    // ----------------------------------------------------------------
    logic aw_full, next_aw_full, w_full, next_w_full;
    logic [3:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic w_lane0, next_w_lane0;  // Byte lane zero enabled.
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic do_write;

    assign s_axi_awready_o = !aw_full && !bvalid;
    assign s_axi_wready_o = !w_full && !bvalid;
    assign s_axi_arready_o = !rvalid;
    assign do_write = aw_full && w_full && !bvalid;
    assign clr_cnt = do_write && aw_addr == REG_CTRL && w_lane0 && w_data[CTRL_CLR];

    // Takes address and data in either order, answers once both are held.
    always_comb begin
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full = w_full;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_lane0 = s_axi_wstrb_i[0];
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = aw_addr[1:0] == 2'h0 ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            case (s_axi_araddr_i)
                REG_STRAP: next_rdata = {{(32-STRAP_W){1'b0}}, strap};
                REG_DECODE: next_rdata = {6'h00, pin_sync[STRAP_W+1], strap_valid, cfg};
                REG_TERM: next_rdata = {disc_cnt, retry_cnt};
                REG_CTRL: next_rdata = 32'h0000_0000;
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
    end

    // Registers the slave state.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
            w_full <= 1'b0;
            w_data <= '0;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= '0;
        end else begin
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full <= next_w_full;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rresp_o = rresp;
    assign s_axi_rdata_o = rdata;

    // ----------------------------------------------------------------
    // Assertions and covers.
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    strap_capture_a: assert property (
        breset_s && !breset_d |=> strap_valid && strap == $past(strap_s))
        else $error("Straps not caught at bus reset release.");
    strap_hold_a: assert property (
        strap_valid && breset_s |=> $stable(strap) && $stable(cfg))
        else $error("Settings changed outside bus reset.");
    row_fallback_a: assert property (
        strap[SB_ROW_MSB:SB_ROW_LSB] > ROW_LAST |-> cfg.row_strobe_timing_sel == ROW_SLOW
        && cfg.ras_precharge_half == 4'h7 && cfg.ras_low_half == 4'hB)
        else $error("Reserved row code not forced to slowest.");
    page_fallback_a: assert property (
        strap[SB_PAGE_MSB:SB_PAGE_LSB] == PAGE_RSVD |-> cfg.page_cycle_type_sel == PAGE_SLOW)
        else $error("Reserved page code not forced to slowest.");
    cfg_fields_a: assert property (
        cfg.byte_write_style_sel == strap[SB_BWS] && cfg.shared_memory_enable == strap[SB_UMA]
        && cfg.external_dot_clock_sel == strap[SB_EDC]
        && cfg.feature_connector_narrow == strap[SB_FCN]
        && cfg.memory_clock_from_cpu == (strap[SB_EMC] && strap[SB_UMA]))
        else $error("Decoded field disagrees with strap.");
    addr9_route_a: assert property (
        cfg.shared_memory_enable && !cfg.addr_bit9_pin_route
        |=> second_write_enable_pin_o == $past(memory_address_bit9_i))
        else $error("Address nine not on write enable pin.");
    stereo_field_a: assert property (
        cfg.stereo_view_enable && interlaced_i ##1 $stable(cfg)
        |-> display_channel_pin_b_o == $past(odd_field_i) && display_channel_pin_b_oe_o)
        else $error("Stereo pin does not follow the field.");
    stereo_low_a: assert property (
        !interlaced_i |=> !display_channel_pin_b_o)
        else $error("Stereo pin high outside interlace.");
    retry_off_a: assert property (
        cfg.bus_retry_disable |-> state != TS_RETRY ##1 state != TS_RETRY)
        else $error("Retry given while retry disabled.");
    cfg_nodisc_a: assert property (
        cfg.cfg_rom_disconnect_disable && cfg_rom_access_i |-> !(stop_o && trdy_o))
        else $error("Config or ROM access disconnected.");
    disc_pair_a: assert property (
        state == TS_XFER && next_state == TS_DISC |-> stop_o && trdy_o ##1 stop_o && !trdy_o)
        else $error("Disconnect without ready on the same clock.");
    retry_clean_a: assert property (
        state == TS_RETRY |-> stop_o && !trdy_o && !trdy_seen)
        else $error("Retry after ready was given.");

    cover_retry_c: cover property (state == TS_XFER ##1 state == TS_RETRY);
    cover_disc_c: cover property (state == TS_XFER ##1 state == TS_DISC);
    cover_capture_c: cover property (breset_s && !breset_d ##1 strap_valid);
    cover_write_c: cover property (do_write ##1 bvalid);

endmodule : psc_strap_config

// >>> verif/psc_strap_model.sv
// Board strap resistor model.
module psc_strap_model (
    input wire logic [17:0] pull_up_i,
    output logic [17:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins without a pull-up sit at the weak pull-down level.
    assign pins_o = pull_up_i;
endmodule : psc_strap_model

// >>> verif/test_power_on_strap_config.sv
// Self-checking bench for the strap capture block.
module test_power_on_strap_config;
    timeunit 1ns;
    timeprecision 1ns;
    import psc_pkg::*;
    logic clock_i = 1'h0, arst_n_i = 1'h0, bus_reset_in_n_i = 1'h0, interlaced_i = 1'h0;
    logic odd_field_i = 1'h0, memory_address_bit9_i = 1'h0, write_enable_b_int_i = 1'h0;
    logic output_enable_int_i = 1'h0, display_channel_pin_b_i = 1'h0, xact_i = 1'h0;
    logic data_ready_i = 1'h0, stop_req_i = 1'h0, cfg_rom_access_i = 1'h0;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, s_axi_awready_o, s_axi_wready_o;
    logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'hF;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [17:0] pull_up = 18'h0, memory_data_strap_pins_i;
    logic second_write_enable_pin_o, output_enable_pin_o, display_channel_pin_b_o;
    logic display_channel_pin_b_oe_o, strap_valid_o, trdy_o, stop_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    psc_cfg_t cfg_o;
    int n_errors = 0, comparisons = 0;
    // Strap sets and their decode: reserved codes first, then a shared-memory set.
    logic [17:0] caps [2] = '{18'h1503F, 18'h2A5E7};
    logic [23:0] exps [2] = '{24'h07B04A, 24'h735B95};
    psc_strap_config dut (.*);
    psc_strap_model straps (.pull_up_i(pull_up), .pins_o(memory_data_strap_pins_i));
    always #25 clock_i = ~clock_i;
    // Compares one value and counts the outcome.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One register read with its expected data and response.
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        do @(posedge clock_i); while (s_axi_arready_o !== 1'h1);
        s_axi_arvalid_i <= 1'h0;
        do @(posedge clock_i); while (s_axi_rvalid_o !== 1'h1);
        // Ready stays up between reads so that a read straight after
        // another never drives it twice in one time step.
        chk("rdata", e, s_axi_rdata_o);
        chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp_o});
    endtask : rd
    // One register write; address and data are offered together.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        do @(posedge clock_i); while ((s_axi_awready_o & s_axi_wready_o) !== 1'h1);
        s_axi_awvalid_i <= 1'h0;
        s_axi_wvalid_i <= 1'h0;
        do @(posedge clock_i); while (s_axi_bvalid_o !== 1'h1);
        s_axi_bready_i <= 1'h0;
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp_o});
    endtask : wr
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // Cuts a hung run short.
    initial begin
        #200us;
        n_errors++;
        summarize();
    end
    // Main sequence.
    initial begin
        repeat (4) @(posedge clock_i);
        arst_n_i <= 1'h1;
        for (int k = 0; k < 2; k++) begin
            @(posedge clock_i);
            bus_reset_in_n_i <= 1'h0;
            pull_up <= caps[k];
            repeat (4) @(posedge clock_i);
            bus_reset_in_n_i <= 1'h1;
            repeat (6) @(posedge clock_i);
            pull_up <= ~caps[k];
            repeat (4) @(posedge clock_i);
            chk("cfg", {8'h0, exps[k]}, {8'h0, cfg_o});
            chk("valid", 32'h1, {31'h0, strap_valid_o});
            rd(REG_STRAP, {14'h0, caps[k]}, RESP_OKAY);
            rd(REG_DECODE, {8'h01, exps[k]}, RESP_OKAY);
        end
        interlaced_i <= 1'h1;
        odd_field_i <= 1'h1;
        memory_address_bit9_i <= 1'h1;
        xact_i <= 1'h1;
        stop_req_i <= 1'h1;
        repeat (3) @(negedge clock_i);
        chk("pin_b", 32'h1, {31'h0, display_channel_pin_b_o});
        chk("pin_b_oe", 32'h1, {31'h0, display_channel_pin_b_oe_o});
        chk("oe_pin", 32'h1, {31'h0, output_enable_pin_o});
        chk("we_pin", 32'h0, {31'h0, second_write_enable_pin_o});
        chk("retry", 32'h1, {30'h0, trdy_o, stop_o});
        // Inputs move only on the rising edge.
        @(posedge clock_i);
        interlaced_i <= 1'h0;
        xact_i <= 1'h0;
        stop_req_i <= 1'h0;
        repeat (3) @(negedge clock_i);
        chk("pin_b", 32'h0, {31'h0, display_channel_pin_b_o});
        @(posedge clock_i);
        xact_i <= 1'h1;
        data_ready_i <= 1'h1;
        stop_req_i <= 1'h1;
        repeat (2) @(negedge clock_i);
        chk("disc", 32'h3, {30'h0, trdy_o, stop_o});
        // The transaction must still stand at the edge that takes the disconnect.
        @(posedge clock_i);
        xact_i <= 1'h0;
        @(posedge clock_i);
        xact_i <= 1'h1;
        cfg_rom_access_i <= 1'h1;
        repeat (2) @(negedge clock_i);
        chk("rom_nodisc", 32'h2, {30'h0, trdy_o, stop_o});
        @(posedge clock_i);
        xact_i <= 1'h0;
        cfg_rom_access_i <= 1'h0;
        rd(REG_TERM, 32'h00010001, RESP_OKAY);
        wr(REG_CTRL, 32'h1);
        rd(REG_TERM, 32'h0, RESP_OKAY);
        rd(4'h2, 32'h0, RESP_SLVERR);
        summarize();
    end
endmodule : test_power_on_strap_config
